// [verilog/qbt_timer_unit.sv]
`timescale 1ns/1ps
// Operation
// - timer_a_low and timer_a_high count independently
// - timer_a pair cascades into 16-bit timer
// - timer_b pair only runs as 16-bit
// - timer_b_high upper byte, timer_b_low lower byte
// - timer_a_high msb, timer_a_low lsb when cascaded
// - each timer has reload and count registers
// - enabled timer decrements to zero, raises irq
// - auto reload copies reload into count
// - single shot stops at zero
// - single shot expiry clears enable bit
// - count write while running resumes from it
// - new reload used at next zero
// - software write beats decrementer write-back
// - hardware enable clear beats software write
// - reads have no side effect
module qbt_timer_unit
  import qbt_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       TICK,
  input  wire qbt_wr_t    WR,
  input  wire qbt_ctl_t   CTL_A,
  input  wire qbt_ctl_t   CTL_A_HIGH,
  input  wire logic       CASCADE_A,
  input  wire qbt_ctl_t   CTL_B,
  input  wire logic [1:0] RD_IDX,
  input  wire qbt_sel_t   RD_SEL,
  output logic [7:0]      RD_DATA,
  output logic            EN_A,
  output logic            EN_A_HIGH,
  output logic            EN_B,
  output logic            IRQ_A_LOW,
  output logic            IRQ_A_HIGH,
  output logic            IRQ_B
);

  qbt_state_t q;
  qbt_state_t next_q;

  logic       run_a_low;
  logic       run_a_high;
  logic       run_b_low;
  logic       dec_a_high;
  logic       dec_b_high;
  logic       zero_a_low;
  logic       zero_a_high;
  logic       zero_b_low;
  logic       zero_b_high;
  logic       exp_a;
  logic       exp_a_high;
  logic       exp_b;

  function automatic logic sw_hit(input qbt_wr_t w, input logic [1:0] i,
                                  input qbt_sel_t s);
    sw_hit = w.en && (w.idx == i) && (w.sel == s);
  endfunction : sw_hit

  always_comb begin
    zero_a_low  = (q.count[QBT_TMR_A_LOW] == QBT_ZERO);
    zero_a_high = (q.count[QBT_TMR_A_HIGH] == QBT_ZERO);
    zero_b_low  = (q.count[QBT_TMR_B_LOW] == QBT_ZERO);
    zero_b_high = (q.count[QBT_TMR_B_HIGH] == QBT_ZERO);
    run_a_low   = q.a_en && TICK;
    run_a_high  = q.a_cascade ? 1'b0 : (q.a_hi_en && TICK);
    run_b_low   = q.b_en && TICK;
    // upper byte steps only when lower byte wraps from zero
    dec_a_high  = q.a_cascade && run_a_low && zero_a_low;
    dec_b_high  = run_b_low && zero_b_low;
    // expiry: whole counter at zero on an enabled tick
    exp_a       = run_a_low && zero_a_low
                  && (!q.a_cascade || zero_a_high);
    exp_a_high  = run_a_high && zero_a_high;
    exp_b       = run_b_low && zero_b_low && zero_b_high;
  end

  always_comb begin
    next_q     = q;
    next_q.irq = {exp_b, exp_a_high, exp_a};
    next_q.a_cascade = CASCADE_A;

    // low byte of timer_a
    if (exp_a) begin
      if (q.a_auto) begin
        next_q.count[QBT_TMR_A_LOW] = q.reload[QBT_TMR_A_LOW];
        if (q.a_cascade) begin
          next_q.count[QBT_TMR_A_HIGH] = q.reload[QBT_TMR_A_HIGH];
        end
      end
    end else if (run_a_low) begin
      next_q.count[QBT_TMR_A_LOW] = q.count[QBT_TMR_A_LOW] - 8'h01;
      if (dec_a_high) begin
        next_q.count[QBT_TMR_A_HIGH] =
          q.count[QBT_TMR_A_HIGH] - 8'h01;
      end
    end

    // high byte of timer_a when running alone
    if (exp_a_high) begin
      if (q.a_hi_auto) begin
        next_q.count[QBT_TMR_A_HIGH] = q.reload[QBT_TMR_A_HIGH];
      end
    end else if (run_a_high) begin
      next_q.count[QBT_TMR_A_HIGH] = q.count[QBT_TMR_A_HIGH] - 8'h01;
    end

    // timer_b_wide
    if (exp_b) begin
      if (q.b_auto) begin
        next_q.count[QBT_TMR_B_LOW]  = q.reload[QBT_TMR_B_LOW];
        next_q.count[QBT_TMR_B_HIGH] = q.reload[QBT_TMR_B_HIGH];
      end
    end else if (run_b_low) begin
      next_q.count[QBT_TMR_B_LOW] = q.count[QBT_TMR_B_LOW] - 8'h01;
      if (dec_b_high) begin
        next_q.count[QBT_TMR_B_HIGH] =
          q.count[QBT_TMR_B_HIGH] - 8'h01;
      end
    end

    // software writes override the decrementer
    for (int i = 0; i < QBT_NUM_TMR; i++) begin
      if (sw_hit(WR, i[1:0], QBT_SEL_COUNT)) begin
        next_q.count[i] = WR.data;
      end
      if (sw_hit(WR, i[1:0], QBT_SEL_RELOAD)) begin
        next_q.reload[i] = WR.data;
      end
    end

    // control bits: software first, hardware clear wins
    if (CTL_A.auto_wr) begin
      next_q.a_auto = CTL_A.auto_val;
    end
    if (CTL_A.en_wr) begin
      next_q.a_en = CTL_A.en_val;
    end
    if (exp_a && !q.a_auto) begin
      next_q.a_en = 1'b0;
    end
    if (CTL_A_HIGH.auto_wr) begin
      next_q.a_hi_auto = CTL_A_HIGH.auto_val;
    end
    if (CTL_A_HIGH.en_wr) begin
      next_q.a_hi_en = CTL_A_HIGH.en_val;
    end
    if (exp_a_high && !q.a_hi_auto) begin
      next_q.a_hi_en = 1'b0;
    end
    if (CTL_B.auto_wr) begin
      next_q.b_auto = CTL_B.auto_val;
    end
    if (CTL_B.en_wr) begin
      next_q.b_en = CTL_B.en_val;
    end
    if (exp_b && !q.b_auto) begin
      next_q.b_en = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q.count     <= {QBT_NUM_TMR{QBT_RST_COUNT}};
      q.reload    <= {QBT_NUM_TMR{QBT_RST_RELOAD}};
      q.a_en      <= 1'b0;
      q.a_auto    <= 1'b0;
      q.a_hi_en   <= 1'b0;
      q.a_hi_auto <= 1'b0;
      q.a_cascade <= 1'b0;
      q.b_en      <= 1'b0;
      q.b_auto    <= 1'b0;
      q.irq       <= 3'h0;
    end else begin
      q <= next_q;
    end
  end

  // read path is purely combinational from state
  always_comb begin
    RD_DATA = (RD_SEL == QBT_SEL_RELOAD) ? q.reload[RD_IDX]
                                         : q.count[RD_IDX];
  end

  assign EN_A       = q.a_en;
  assign EN_A_HIGH  = q.a_hi_en;
  assign EN_B       = q.b_en;
  assign IRQ_A_LOW  = q.irq[0];
  assign IRQ_A_HIGH = q.irq[1];
  assign IRQ_B      = q.irq[2];

  // checks
  property p_dec;
    @(posedge CLK) disable iff (!RST_B)
      (run_a_low && !zero_a_low && !WR.en)
        |=> q.count[QBT_TMR_A_LOW] == $past(q.count[QBT_TMR_A_LOW]) - 8'h01;
  endproperty
  a_dec: assert property (p_dec)
    else $error("count did not decrement");

  property p_irq;
    @(posedge CLK) disable iff (!RST_B) exp_b |=> IRQ_B;
  endproperty
  a_irq: assert property (p_irq) else $error("no irq at zero");

  property p_reload;
    @(posedge CLK) disable iff (!RST_B)
      (exp_b && q.b_auto && !WR.en)
        |=> q.count[QBT_TMR_B_LOW] == $past(q.reload[QBT_TMR_B_LOW]);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_shot;
    @(posedge CLK) disable iff (!RST_B) (exp_a && !q.a_auto) |=> !EN_A;
  endproperty
  a_shot: assert property (p_shot)
    else $error("single shot enable kept");

  property p_hw_wins;
    @(posedge CLK) disable iff (!RST_B)
      (exp_b && !q.b_auto && CTL_B.en_wr && CTL_B.en_val) |=> !EN_B;
  endproperty
  a_hw_wins: assert property (p_hw_wins)
    else $error("sw beat hw clear");

  property p_sw_wins;
    @(posedge CLK) disable iff (!RST_B)
      sw_hit(WR, QBT_TMR_B_LOW, QBT_SEL_COUNT)
        |=> q.count[QBT_TMR_B_LOW] == $past(WR.data);
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("sw write lost");

  property p_high_hold;
    @(posedge CLK) disable iff (!RST_B)
      (run_b_low && !zero_b_low && !WR.en)
        |=> $stable(q.count[QBT_TMR_B_HIGH]);
  endproperty
  a_high_hold: assert property (p_high_hold)
    else $error("upper moved");

  property p_casc_high;
    @(posedge CLK) disable iff (!RST_B)
      (q.a_cascade && !dec_a_high && !exp_a && !WR.en)
        |=> $stable(q.count[QBT_TMR_A_HIGH]);
  endproperty
  a_casc_high: assert property (p_casc_high) else $error("msb moved");

  property p_hw_wins_a;
    @(posedge CLK) disable iff (!RST_B)
      (exp_a && !q.a_auto && CTL_A.en_wr && CTL_A.en_val) |=> !EN_A;
  endproperty
  a_hw_wins_a: assert property (p_hw_wins_a)
    else $error("sw beat hw clear on timer a");

  property p_irq_a;
    @(posedge CLK) disable iff (!RST_B) exp_a |=> IRQ_A_LOW;
  endproperty
  a_irq_a: assert property (p_irq_a)
    else $error("no irq on timer a");

  property p_solo_high;
    @(posedge CLK) disable iff (!RST_B)
      (run_a_high && !zero_a_high && !WR.en)
        |=> q.count[QBT_TMR_A_HIGH] == $past(q.count[QBT_TMR_A_HIGH]) - 8'h01;
  endproperty
  a_solo_high: assert property (p_solo_high)
    else $error("solo upper byte did not decrement");

  property p_wrap_b;
    @(posedge CLK) disable iff (!RST_B)
      (dec_b_high && !exp_b && !WR.en)
        |=> q.count[QBT_TMR_B_LOW] == QBT_ONES;
  endproperty
  a_wrap_b: assert property (p_wrap_b)
    else $error("lower byte did not wrap");

  property p_shot_stop;
    @(posedge CLK) disable iff (!RST_B)
      (exp_b && !q.b_auto && !WR.en)
        |=> q.count[QBT_TMR_B_LOW] == QBT_ZERO
            && q.count[QBT_TMR_B_HIGH] == QBT_ZERO && !EN_B;
  endproperty
  a_shot_stop: assert property (p_shot_stop)
    else $error("single shot did not stop at zero");

  property p_reload_wr;
    @(posedge CLK) disable iff (!RST_B)
      sw_hit(WR, QBT_TMR_A_LOW, QBT_SEL_RELOAD)
        |=> q.reload[QBT_TMR_A_LOW] == $past(WR.data);
  endproperty
  a_reload_wr: assert property (p_reload_wr)
    else $error("reload write lost");

  property p_reload_a;
    @(posedge CLK) disable iff (!RST_B)
      (exp_a && q.a_auto && !WR.en)
        |=> q.count[QBT_TMR_A_LOW] == $past(q.reload[QBT_TMR_A_LOW]);
  endproperty
  a_reload_a: assert property (p_reload_a)
    else $error("new reload not taken");

  c_exp_a: cover property (@(posedge CLK) disable iff (!RST_B) exp_a);
  c_exp_b: cover property (@(posedge CLK) disable iff (!RST_B)
                           exp_b && q.b_auto);
  c_casc:  cover property (@(posedge CLK) disable iff (!RST_B) dec_a_high);
  c_wrap_b: cover property (@(posedge CLK) disable iff (!RST_B) dec_b_high);
  c_hw_clr: cover property (@(posedge CLK) disable iff (!RST_B)
                            exp_a && !q.a_auto && CTL_A.en_wr);

endmodule : qbt_timer_unit

// [verilog/qbt_pkg.sv]
package qbt_pkg;

  localparam int unsigned QBT_BYTE_W   = 8;
  localparam int unsigned QBT_NUM_TMR  = 4;
  localparam int unsigned QBT_IDX_W    = 2;

  localparam logic [1:0] QBT_TMR_A_LOW  = 2'h0;
  localparam logic [1:0] QBT_TMR_A_HIGH = 2'h1;
  localparam logic [1:0] QBT_TMR_B_LOW  = 2'h2;
  localparam logic [1:0] QBT_TMR_B_HIGH = 2'h3;

  localparam logic [7:0] QBT_RST_COUNT  = 8'h00;
  localparam logic [7:0] QBT_RST_RELOAD = 8'h00;
  localparam logic [7:0] QBT_ZERO       = 8'h00;
  localparam logic [7:0] QBT_ONES       = 8'hff;

  typedef enum logic [1:0] {
    QBT_SEL_RELOAD = 2'h1,
    QBT_SEL_COUNT  = 2'h2
  } qbt_sel_t;

  typedef struct packed {
    logic       en;
    logic [1:0] idx;
    qbt_sel_t   sel;
    logic [7:0] data;
  } qbt_wr_t;

  typedef struct packed {
    logic       en_wr;
    logic       en_val;
    logic       auto_wr;
    logic       auto_val;
  } qbt_ctl_t;

  typedef struct packed {
    logic [3:0][7:0] count;
    logic [3:0][7:0] reload;
    logic            a_en;
    logic            a_auto;
    logic            a_hi_en;
    logic            a_hi_auto;
    logic            a_cascade;
    logic            b_en;
    logic            b_auto;
    logic [2:0]      irq;
  } qbt_state_t;

endpackage : qbt_pkg

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import qbt_pkg::*;
  localparam qbt_sel_t RL = QBT_SEL_RELOAD;
  localparam qbt_sel_t CN = QBT_SEL_COUNT;
  localparam qbt_ctl_t ONE = '{1'b1, 1'b1, 1'b1, 1'b0};
  localparam qbt_ctl_t AUTO = '{1'b1, 1'b1, 1'b1, 1'b1};
  localparam qbt_ctl_t STOP = '{1'b1, 1'b0, 1'b0, 1'b0};
  localparam qbt_ctl_t GO = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        TICK = 1'b1;
  logic        CASCADE_A = 1'b0;
  qbt_wr_t     WR = '0;
  qbt_ctl_t    CTL_A = '0;
  qbt_ctl_t    CTL_A_HIGH = '0;
  qbt_ctl_t    CTL_B = '0;
  logic [1:0]  RD_IDX = 2'h0;
  qbt_sel_t    RD_SEL = QBT_SEL_COUNT;
  logic [7:0]  RD_DATA;
  logic        EN_A;
  logic        EN_A_HIGH;
  logic        EN_B;
  logic        IRQ_A_LOW;
  logic        IRQ_A_HIGH;
  logic        IRQ_B;
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [18:0] exp_q[$];

  always #12.5 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;

  qbt_timer_unit i_qbt_timer_unit (
    .CLK(CLK), .RST_B(RST_B), .TICK(TICK), .WR(WR), .CTL_A(CTL_A),
    .CTL_A_HIGH(CTL_A_HIGH), .CASCADE_A(CASCADE_A), .CTL_B(CTL_B),
    .RD_IDX(RD_IDX), .RD_SEL(RD_SEL), .RD_DATA(RD_DATA), .EN_A(EN_A),
    .EN_A_HIGH(EN_A_HIGH), .EN_B(EN_B), .IRQ_A_LOW(IRQ_A_LOW),
    .IRQ_A_HIGH(IRQ_A_HIGH), .IRQ_B(IRQ_B)
  );

  task automatic chk(input logic [18:0] e, input logic [18:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // irq watcher: oldest note is {cycle, irq vector}
  always @(negedge CLK) begin
    if (RST_B && {IRQ_B, IRQ_A_HIGH, IRQ_A_LOW} !== 3'h0) begin
      if (exp_q.size() == 0) begin
        chk(19'h0, {cyc[15:0], IRQ_B, IRQ_A_HIGH, IRQ_A_LOW});
      end else begin
        chk(exp_q.pop_front(), {cyc[15:0], IRQ_B, IRQ_A_HIGH, IRQ_A_LOW});
      end
    end
  end

  task automatic till(input int c);
    for (int i = 0; i < 5000 && cyc < c; i++) @(negedge CLK);
    if (cyc != c) begin
      mismatches++;
      results();
    end
  endtask : till

  // strobes hold what they were given until the next drive
  task automatic drv(input qbt_wr_t w, input qbt_ctl_t a,
                     input qbt_ctl_t ah, input qbt_ctl_t b);
    WR = w;
    CTL_A = a;
    CTL_A_HIGH = ah;
    CTL_B = b;
    @(negedge CLK);
  endtask : drv

  task automatic idle;
    drv('0, '0, '0, '0);
  endtask : idle

  task automatic wr(input logic [1:0] i, input qbt_sel_t s,
                    input logic [7:0] d);
    drv('{1'b1, i, s, d}, '0, '0, '0);
  endtask : wr

  task automatic rd(input logic [1:0] i, input qbt_sel_t s,
                    input logic [7:0] e);
    RD_IDX = i;
    RD_SEL = s;
    #1;
    chk({11'h0, e}, {11'h0, RD_DATA});
    @(negedge CLK);
  endtask : rd

  initial begin
    int          w;
    logic [15:0] v;
    logic [7:0]  lo;
    logic [7:0]  hi;
    void'($urandom(32'h4df5));
    repeat (4) @(negedge CLK);
    RST_B = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), RL, QBT_RST_RELOAD);
      rd(2'(i), CN, QBT_RST_COUNT);
    end
    chk(19'h0, {16'h0, EN_B, EN_A_HIGH, EN_A});
    // wide b single shot, mid-run reads and a tick stall
    v = 16'(260 + $urandom_range(700));
    wr(2'h3, CN, v[15:8]);
    w = cyc + 1;
    exp_q.push_back({16'(w + v + 3), 3'h4});
    drv('{1'b1, 2'h2, CN, v[7:0]}, '0, '0, ONE);
    idle();
    till(w + 3);
    rd(2'h2, CN, 8'(v - 3));
    rd(2'h3, CN, 8'((v - 4) >> 8));
    TICK = 1'b0;
    rd(2'h2, CN, 8'(v - 5));
    rd(2'h2, CN, 8'(v - 5));
    TICK = 1'b1;
    till(w + v + 3);
    chk(19'h0, {18'h0, EN_B});
    rd(2'h2, CN, QBT_ZERO);
    rd(2'h3, CN, QBT_ZERO);
    // wide b auto reload across a byte borrow
    wr(2'h2, RL, 8'h02);
    wr(2'h3, RL, 8'h01);
    wr(2'h3, CN, 8'h00);
    w = cyc + 1;
    exp_q.push_back({16'(w + 2), 3'h4});
    exp_q.push_back({16'(w + 261), 3'h4});
    drv('{1'b1, 2'h2, CN, 8'h01}, '0, '0, AUTO);
    idle();
    till(w + 262);
    drv('0, '0, '0, STOP);
    idle();
    chk(19'h0, {18'h0, EN_B});
    rd(2'h3, CN, 8'h01);
    rd(2'h2, CN, 8'h00);
    // a pair as two independent single shots
    lo = 8'($urandom_range(40, 10));
    hi = lo + 8'($urandom_range(20, 3));
    wr(2'h1, CN, hi);
    w = cyc + 1;
    exp_q.push_back({16'(w + lo + 1), 3'h1});
    exp_q.push_back({16'(w + hi + 1), 3'h2});
    drv('{1'b1, 2'h0, CN, lo}, ONE, ONE, '0);
    idle();
    till(w + hi + 2);
    chk(19'h0, {17'h0, EN_A_HIGH, EN_A});
    // auto reload, reload change, count overwrite
    wr(2'h0, RL, 8'h05);
    w = cyc + 1;
    exp_q.push_back({16'(w + 4), 3'h1});
    exp_q.push_back({16'(w + 10), 3'h1});
    exp_q.push_back({16'(w + 15), 3'h1});
    exp_q.push_back({16'(w + 24), 3'h1});
    drv('{1'b1, 2'h0, CN, 8'h03}, AUTO, '0, '0);
    idle();
    till(w + 5);
    rd(2'h0, CN, 8'h04);
    wr(2'h0, RL, 8'h08);
    idle();
    till(w + 11);
    wr(2'h0, CN, 8'h02);
    idle();
    till(w + 25);
    drv('0, STOP, '0, '0);
    idle();
    till(w + 40);
    chk(19'h0, {18'h0, EN_A});
    // cascade single shot, enable write at expiry
    CASCADE_A = 1'b1;
    idle();
    v = 16'(300 + $urandom_range(500));
    wr(2'h1, CN, v[15:8]);
    w = cyc + 1;
    exp_q.push_back({16'(w + v + 1), 3'h1});
    drv('{1'b1, 2'h0, CN, v[7:0]}, ONE, '0, '0);
    idle();
    till(w + v);
    drv('0, GO, '0, '0);
    chk(19'h0, {18'h0, EN_A});
    idle();
    repeat (3) @(negedge CLK);
    chk(19'h0, 19'(exp_q.size()));
    results();
  end
endmodule : tb
